//--- verilog/ifm_pkg.sv
`default_nettype none
package ifm_pkg;
  localparam int BYTE_W = 8;
  localparam int NUM_BYTES = 7;
  localparam int FLAGS_W = 56;
  localparam int NUM_PINS = 8;

  // Flag bytes in order: group0 low, group0 high, group1 low, group1 high,
  // group2 low, group2 high, group3 low. Flat bit index is byte * 8 + bit.
  localparam logic [2:0] BYTE_G0_LOW = 3'h0;
  localparam logic [2:0] BYTE_G0_HIGH = 3'h1;
  localparam logic [2:0] BYTE_G1_LOW = 3'h2;

  // Implemented flag positions; the others are fixed (request 0, mask 1).
  localparam logic [55:0] IMPL_MASK = 56'h1C5FDF1FFFE7FF;

  localparam logic [55:0] REQ_RST = 56'h00000000000000;
  localparam logic [55:0] MASK_RST = 56'hFFFFFFFFFFFFFF;
  localparam logic [55:0] PRIO_RST = 56'hFFFFFFFFFFFFFF;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;

  localparam logic [55:0] ONE_BIT = 56'h00000000000001;
  localparam logic [55:0] ONE_BYTE = 56'h000000000000FF;
  localparam logic [55:0] NO_BITS = 56'h00000000000000;

  // Register groups selected by the write port.
  localparam logic [2:0] GRP_REQ = 3'h0;
  localparam logic [2:0] GRP_MASK = 3'h1;
  localparam logic [2:0] GRP_PRIO0 = 3'h2;
  localparam logic [2:0] GRP_PRIO1 = 3'h3;
  localparam logic [2:0] GRP_RISE = 3'h4;
  localparam logic [2:0] GRP_FALL = 3'h5;
  localparam logic [2:0] GRP_PSW = 3'h6;

  // Write operations: whole byte, single-bit set, single-bit clear.
  localparam logic [1:0] OP_BYTE = 2'h0;
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_CLR = 2'h2;

  // Bit positions inside their byte for the shared request bits.
  localparam logic [2:0] SHARED_SER0_BIT = 3'h5;
  localparam logic [2:0] SHARED_RXA_BIT = 3'h0;
  localparam logic [2:0] SHARED_TX2_BIT = 3'h1;
  localparam logic [2:0] SHARED_RXB_BIT = 3'h3;

  // Flat request positions of the external pins 0 to 7.
  localparam int PIN_POS [NUM_PINS] = '{2, 3, 4, 5, 6, 7, 35, 36};
endpackage
`default_nettype wire

//--- verilog/ifm_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ifm_edge_if;
  logic [ifm_pkg::NUM_PINS-1:0] rise_en;
  logic [ifm_pkg::NUM_PINS-1:0] fall_en;
  logic [ifm_pkg::NUM_PINS-1:0] edge_evt;
  modport det (input rise_en, input fall_en, output edge_evt);
  modport ctl (output rise_en, output fall_en, input edge_evt);
endinterface
`default_nettype wire

//--- verilog/ifm_pin_edge.sv
`timescale 1ns/1ps
`default_nettype none
module ifm_pin_edge (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ifm_pkg::NUM_PINS-1:0] pins_in,
  ifm_edge_if.det edge_bus
);
  logic [ifm_pkg::NUM_PINS-1:0] sync1_r;
  logic [ifm_pkg::NUM_PINS-1:0] sync2_r;
  logic [ifm_pkg::NUM_PINS-1:0] prev_r;
  wire [ifm_pkg::NUM_PINS-1:0] rise_seen = sync2_r & ~prev_r;
  wire [ifm_pkg::NUM_PINS-1:0] fall_seen = ~sync2_r & prev_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // The two enables are independent, so both edges may raise the flag.
  assign edge_bus.edge_evt = (rise_seen & edge_bus.rise_en) |
                             (fall_seen & edge_bus.fall_en);
endmodule
`default_nettype wire

//--- verilog/ifm_flag_map.sv
// Notes on behaviour
// - Six register kinds control interrupts.
// - Each source: request, mask, two priority flags.
// - Per-pin rising edge enable raises request.
// - Independent per-pin falling edge enable.
// - Three serial-0 events share group0-high bit5.
// - Rx error A or timer1 upper: g1-low bit0.
// - Serial2 tx or two-wire1: g1-low bit1.
// - Rx error B or timer3 upper: g1-low bit3.
// - Request set by source/software, cleared on acknowledge.
// - Request flags reset to all zeros.
// - Mask flags reset to all ones.
`timescale 1ns/1ps
`default_nettype none
module ifm_flag_map (
  input wire logic SYS_CLK_IN, // System clock, 125 MHz.
  input wire logic SYS_RST_IN, // Asynchronous reset, active high.
  input wire logic [55:0] SRC_IRQ_IN, // Dedicated source pulses, flat index.
  input wire logic SERIAL0_TX_END_IRQ_IN, // Shared serial-0 source.
  input wire logic CLOCKED_SERIAL0_END_IRQ_IN, // Shared serial-0 source.
  input wire logic TWO_WIRE0_END_IRQ_IN, // Shared serial-0 source.
  input wire logic SERIAL_RX_ERROR_IRQ_A_IN, // Shared with timer channel 1 upper.
  input wire logic TIMER_CH1_UPPER_IRQ_IN, // Shared with rx error A.
  input wire logic SERIAL2_TX_END_IRQ_IN, // Shared with two-wire channel 1.
  input wire logic TWO_WIRE1_END_IRQ_IN, // Shared with serial 2 tx end.
  input wire logic SERIAL_RX_ERROR_IRQ_B_IN, // Shared with timer channel 3 upper.
  input wire logic TIMER_CH3_UPPER_IRQ_IN, // Shared with rx error B.
  input wire logic [7:0] EXT_PIN_IN, // External interrupt pins, asynchronous.
  input wire logic WR_STB_IN, // Write strobe, one cycle.
  input wire logic [1:0] WR_OP_IN, // Byte write, bit set or bit clear.
  input wire logic [2:0] WR_GRP_IN, // Register group select.
  input wire logic [2:0] WR_BYTE_IN, // Byte within a flag group.
  input wire logic [2:0] WR_BIT_IN, // Bit for single-bit operations.
  input wire logic [7:0] WR_DATA_IN, // Data for byte writes.
  input wire logic ACK_STB_IN, // Core acknowledges an interrupt.
  input wire logic [5:0] ACK_IDX_IN, // Flat index of acknowledged flag.
  output logic [55:0] REQ_FLAGS_OUT, // Request flags.
  output logic [55:0] MASK_FLAGS_OUT, // Mask flags.
  output logic [55:0] PRIO0_FLAGS_OUT, // Priority specification flags 0.
  output logic [55:0] PRIO1_FLAGS_OUT, // Priority specification flags 1.
  output logic [7:0] RISING_EDGE_ENABLE_OUT, // Rising edge enables.
  output logic [7:0] FALLING_EDGE_ENABLE_OUT, // Falling edge enables.
  output logic [7:0] PROGRAM_STATUS_WORD_OUT, // Program status word.
  output logic [55:0] PEND_OUT // Requests forwarded to arbitration.
);
  logic [55:0] req_r;
  logic [55:0] req_nxt;
  logic [55:0] mask_r;
  logic [55:0] mask_nxt;
  logic [55:0] prio0_r;
  logic [55:0] prio0_nxt;
  logic [55:0] prio1_r;
  logic [55:0] prio1_nxt;
  logic [7:0] rise_r;
  logic [7:0] rise_nxt;
  logic [7:0] fall_r;
  logic [7:0] fall_nxt;
  logic [7:0] psw_r;
  logic [7:0] psw_nxt;
  logic [55:0] pend_r;
  logic [55:0] pend_nxt;

  ifm_edge_if edge_bus ();

  assign edge_bus.rise_en = rise_r;
  assign edge_bus.fall_en = fall_r;

  ifm_pin_edge u_pin_edge (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .pins_in(EXT_PIN_IN),
    .edge_bus(edge_bus)
  );

  // Write decode.
  wire op_ok = (WR_OP_IN == ifm_pkg::OP_BYTE) || (WR_OP_IN == ifm_pkg::OP_SET) ||
               (WR_OP_IN == ifm_pkg::OP_CLR);
  wire wr_ok = WR_STB_IN && op_ok;
  wire byte_ok = 32'(WR_BYTE_IN) < ifm_pkg::NUM_BYTES;
  wire hit_req = wr_ok && byte_ok && (WR_GRP_IN == ifm_pkg::GRP_REQ);
  wire hit_mask = wr_ok && byte_ok && (WR_GRP_IN == ifm_pkg::GRP_MASK);
  wire hit_prio0 = wr_ok && byte_ok && (WR_GRP_IN == ifm_pkg::GRP_PRIO0);
  wire hit_prio1 = wr_ok && byte_ok && (WR_GRP_IN == ifm_pkg::GRP_PRIO1);
  wire hit_rise = wr_ok && (WR_GRP_IN == ifm_pkg::GRP_RISE);
  wire hit_fall = wr_ok && (WR_GRP_IN == ifm_pkg::GRP_FALL);
  wire hit_psw = wr_ok && (WR_GRP_IN == ifm_pkg::GRP_PSW);

  wire [5:0] byte_base = {WR_BYTE_IN, 3'h0};
  wire [5:0] bit_pos = {WR_BYTE_IN, WR_BIT_IN};
  wire is_byte = WR_OP_IN == ifm_pkg::OP_BYTE;
  wire is_set = WR_OP_IN == ifm_pkg::OP_SET;
  // A bit operation touches one flag only, so other flags of the byte keep their value.
  wire [55:0] wmask = is_byte ? (ifm_pkg::ONE_BYTE << byte_base)
                              : (ifm_pkg::ONE_BIT << bit_pos);
  wire [55:0] wval = is_byte ? (56'(WR_DATA_IN) << byte_base)
                             : (is_set ? wmask : ifm_pkg::NO_BITS);
  wire [7:0] bit8 = 8'h01 << WR_BIT_IN;

  // Acknowledge clears exactly the acknowledged flag.
  wire ack_ok = ACK_STB_IN && (32'(ACK_IDX_IN) < ifm_pkg::FLAGS_W);
  wire [55:0] ack_clr = ack_ok ? (ifm_pkg::ONE_BIT << ACK_IDX_IN)
                               : ifm_pkg::NO_BITS;

  // Shared request bits: any member event sets the one flag.
  wire ser0_any = SERIAL0_TX_END_IRQ_IN | CLOCKED_SERIAL0_END_IRQ_IN |
                  TWO_WIRE0_END_IRQ_IN;
  wire rxa_any = SERIAL_RX_ERROR_IRQ_A_IN | TIMER_CH1_UPPER_IRQ_IN;
  wire tx2_any = SERIAL2_TX_END_IRQ_IN | TWO_WIRE1_END_IRQ_IN;
  wire rxb_any = SERIAL_RX_ERROR_IRQ_B_IN | TIMER_CH3_UPPER_IRQ_IN;
  wire [55:0] shared_set =
    (56'(ser0_any) << {ifm_pkg::BYTE_G0_HIGH, ifm_pkg::SHARED_SER0_BIT}) |
    (56'(rxa_any) << {ifm_pkg::BYTE_G1_LOW, ifm_pkg::SHARED_RXA_BIT}) |
    (56'(tx2_any) << {ifm_pkg::BYTE_G1_LOW, ifm_pkg::SHARED_TX2_BIT}) |
    (56'(rxb_any) << {ifm_pkg::BYTE_G1_LOW, ifm_pkg::SHARED_RXB_BIT});

  logic [55:0] pin_set;
  always_comb begin
    pin_set = ifm_pkg::NO_BITS;
    for (int p = 0; p < ifm_pkg::NUM_PINS; p++) begin
      pin_set[ifm_pkg::PIN_POS[p]] = edge_bus.edge_evt[p];
    end
  end

  wire [55:0] hw_set = SRC_IRQ_IN | shared_set | pin_set;

  function automatic logic [55:0] upd56(input logic [55:0] cur, input logic hit,
                                        input logic [55:0] m, input logic [55:0] v);
    upd56 = hit ? ((cur & ~m) | (v & m)) : cur;
  endfunction

  function automatic logic [7:0] upd8(input logic [7:0] cur, input logic hit,
                                      input logic byte_op, input logic set_op,
                                      input logic [7:0] b, input logic [7:0] d);
    if (!hit) begin
      upd8 = cur;
    end else if (byte_op) begin
      upd8 = d;
    end else if (set_op) begin
      upd8 = cur | b;
    end else begin
      upd8 = cur & ~b;
    end
  endfunction

  // A hardware set in the same cycle wins over any clear by write or acknowledge.
  assign req_nxt = (((upd56(req_r, hit_req, wmask, wval) & ~ack_clr) | hw_set) &
                    ifm_pkg::IMPL_MASK);
  assign mask_nxt = upd56(mask_r, hit_mask, wmask, wval) | ~ifm_pkg::IMPL_MASK;
  assign prio0_nxt = upd56(prio0_r, hit_prio0, wmask, wval) | ~ifm_pkg::IMPL_MASK;
  assign prio1_nxt = upd56(prio1_r, hit_prio1, wmask, wval) | ~ifm_pkg::IMPL_MASK;
  assign rise_nxt = upd8(rise_r, hit_rise, is_byte, is_set, bit8, WR_DATA_IN);
  assign fall_nxt = upd8(fall_r, hit_fall, is_byte, is_set, bit8, WR_DATA_IN);
  assign psw_nxt = upd8(psw_r, hit_psw, is_byte, is_set, bit8, WR_DATA_IN);
  assign pend_nxt = req_nxt & ~mask_nxt;

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      req_r <= ifm_pkg::REQ_RST;
    end else begin
      req_r <= req_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      mask_r <= ifm_pkg::MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      prio0_r <= ifm_pkg::PRIO_RST;
    end else begin
      prio0_r <= prio0_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      prio1_r <= ifm_pkg::PRIO_RST;
    end else begin
      prio1_r <= prio1_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rise_r <= ifm_pkg::EDGE_RST;
    end else begin
      rise_r <= rise_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      fall_r <= ifm_pkg::EDGE_RST;
    end else begin
      fall_r <= fall_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      psw_r <= ifm_pkg::PSW_RST;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      pend_r <= ifm_pkg::NO_BITS;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign REQ_FLAGS_OUT = req_r;
  assign MASK_FLAGS_OUT = mask_r;
  assign PRIO0_FLAGS_OUT = prio0_r;
  assign PRIO1_FLAGS_OUT = prio1_r;
  assign RISING_EDGE_ENABLE_OUT = rise_r;
  assign FALLING_EDGE_ENABLE_OUT = fall_r;
  assign PROGRAM_STATUS_WORD_OUT = psw_r;
  assign PEND_OUT = pend_r;
endmodule
`default_nettype wire

//--- verif/ifm_flag_map_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ifm_flag_map_asserts (
  input wire logic SYS_CLK_IN, SYS_RST_IN, WR_STB_IN, ACK_STB_IN, SERIAL0_TX_END_IRQ_IN,
  input wire logic SERIAL_RX_ERROR_IRQ_A_IN, TWO_WIRE1_END_IRQ_IN, TIMER_CH3_UPPER_IRQ_IN,
  input wire logic [55:0] SRC_IRQ_IN, REQ_FLAGS_OUT, MASK_FLAGS_OUT, PEND_OUT,
  input wire logic [1:0] WR_OP_IN,
  input wire logic [2:0] WR_GRP_IN, WR_BYTE_IN, WR_BIT_IN,
  input wire logic [5:0] ACK_IDX_IN
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  wire logic [55:0] clr_bit = ifm_pkg::ONE_BIT << {WR_BYTE_IN, WR_BIT_IN};
  wire logic clr_op = WR_STB_IN && WR_OP_IN == ifm_pkg::OP_CLR && WR_GRP_IN == ifm_pkg::GRP_REQ;
  sequence ack20_s;
    ACK_STB_IN && ACK_IDX_IN == 6'h14 && !SRC_IRQ_IN[20] && !WR_STB_IN;
  endsequence
  reset_value_a: assert property ($past(SYS_RST_IN) |-> REQ_FLAGS_OUT == 56'h0
    && MASK_FLAGS_OUT == ifm_pkg::MASK_RST) else $error("flags not at reset value");
  pend_gate_a: assert property (PEND_OUT == (REQ_FLAGS_OUT & ~MASK_FLAGS_OUT))
    else $error("pending differs from request and mask");
  ser0_shared_a: assert property (SERIAL0_TX_END_IRQ_IN |=> REQ_FLAGS_OUT[13])
    else $error("serial 0 event missed bit 13");
  rx_a_shared_a: assert property (SERIAL_RX_ERROR_IRQ_A_IN |=> REQ_FLAGS_OUT[16])
    else $error("rx error event missed bit 16");
  tw1_shared_a: assert property (TWO_WIRE1_END_IRQ_IN |=> REQ_FLAGS_OUT[17])
    else $error("two-wire event missed bit 17");
  tm3_shared_a: assert property (TIMER_CH3_UPPER_IRQ_IN |=> REQ_FLAGS_OUT[19])
    else $error("timer 3 event missed bit 19");
  ack_clear_a: assert property (ack20_s |=> !REQ_FLAGS_OUT[20])
    else $error("acknowledge did not clear bit 20");
  bit_clr_keep_a: assert property (clr_op && !ACK_STB_IN |=>
    (($past(REQ_FLAGS_OUT) & ~$past(clr_bit)) & ~REQ_FLAGS_OUT) == 56'h0)
    else $error("bit clear dropped another flag");
endmodule
bind ifm_flag_map ifm_flag_map_asserts i_ifm_flag_map_asserts (.SYS_CLK_IN(SYS_CLK_IN),
  .SYS_RST_IN(SYS_RST_IN), .WR_STB_IN(WR_STB_IN), .ACK_STB_IN(ACK_STB_IN),
  .SERIAL0_TX_END_IRQ_IN(SERIAL0_TX_END_IRQ_IN),
  .SERIAL_RX_ERROR_IRQ_A_IN(SERIAL_RX_ERROR_IRQ_A_IN),
  .TWO_WIRE1_END_IRQ_IN(TWO_WIRE1_END_IRQ_IN), .TIMER_CH3_UPPER_IRQ_IN(TIMER_CH3_UPPER_IRQ_IN),
  .SRC_IRQ_IN(SRC_IRQ_IN), .REQ_FLAGS_OUT(REQ_FLAGS_OUT), .MASK_FLAGS_OUT(MASK_FLAGS_OUT),
  .PEND_OUT(PEND_OUT), .WR_OP_IN(WR_OP_IN), .WR_GRP_IN(WR_GRP_IN), .WR_BYTE_IN(WR_BYTE_IN),
  .WR_BIT_IN(WR_BIT_IN), .ACK_IDX_IN(ACK_IDX_IN));
`default_nettype wire

//--- verif/ifm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ifm_core_model (
  input wire logic clk_in, // Clock.
  input wire logic rst_in, // Reset, active high.
  input wire logic go_in, // Acknowledge request.
  input wire logic [5:0] idx_in, // Flag to acknowledge.
  output logic ack_out, // Acknowledge strobe.
  output logic [5:0] idx_out // Acknowledged index.
);
  // An idle index toggles every cycle so a stale value never looks valid.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      idx_out <= 6'h2A;
    end else begin
      ack_out <= go_in;
      idx_out <= go_in ? idx_in : ~idx_out;
    end
  end
endmodule
`default_nettype wire

//--- verif/ifm_flag_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ifm_flag_map_tb;
  logic clk = 1'b0, rst = 1'b1, ws = 1'b0, go = 1'b0, as;
  logic [8:0] sh = 9'h000;
  logic [7:0] pins = 8'h00, wd = 8'h00, re, fe, program_status_word;
  logic [1:0] wo = 2'h0;
  logic [2:0] wg = 3'h0, wb = 3'h0, wi = 3'h0;
  logic [5:0] gi = 6'h00, ai;
  logic [55:0] src = 56'h0, req, msk, p0, p1, pnd, m_req, m_msk, m_p0, m_p1;
  logic [63:0] w;
  logic [31:0] seed = 32'h37C05454;
  int errors = 0;
  int compares = 0;
  int sh_pos [9] = '{13, 13, 13, 16, 16, 17, 17, 19, 19};
  ifm_flag_map i_ifm_flag_map (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .SRC_IRQ_IN(src),
    .SERIAL0_TX_END_IRQ_IN(sh[0]), .CLOCKED_SERIAL0_END_IRQ_IN(sh[1]),
    .TWO_WIRE0_END_IRQ_IN(sh[2]), .SERIAL_RX_ERROR_IRQ_A_IN(sh[3]), .TIMER_CH1_UPPER_IRQ_IN(sh[4]),
    .SERIAL2_TX_END_IRQ_IN(sh[5]), .TWO_WIRE1_END_IRQ_IN(sh[6]), .SERIAL_RX_ERROR_IRQ_B_IN(sh[7]),
    .TIMER_CH3_UPPER_IRQ_IN(sh[8]), .EXT_PIN_IN(pins), .WR_STB_IN(ws), .WR_OP_IN(wo),
    .WR_GRP_IN(wg), .WR_BYTE_IN(wb), .WR_BIT_IN(wi), .WR_DATA_IN(wd), .ACK_STB_IN(as),
    .ACK_IDX_IN(ai), .REQ_FLAGS_OUT(req), .MASK_FLAGS_OUT(msk), .PRIO0_FLAGS_OUT(p0),
    .PRIO1_FLAGS_OUT(p1), .RISING_EDGE_ENABLE_OUT(re), .FALLING_EDGE_ENABLE_OUT(fe),
    .PROGRAM_STATUS_WORD_OUT(program_status_word), .PEND_OUT(pnd));
  ifm_core_model i_ifm_core_model (.clk_in(clk), .rst_in(rst), .go_in(go), .idx_in(gi),
    .ack_out(as), .idx_out(ai));
  initial begin
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string name, input logic [55:0] seen, input logic [55:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] op, input logic [2:0] g, input logic [2:0] b,
                    input logic [2:0] i, input logic [7:0] v);
    ws = 1'b1;
    wo = op;
    wg = g;
    wb = b;
    wi = i;
    wd = v;
    cyc();
    ws = 1'b0;
    cyc();
  endtask
  task automatic ack(input int idx);
    go = 1'b1;
    gi = idx[5:0];
    cyc();
    go = 1'b0;
    cyc();
    if (idx < 56) m_req[idx] = 1'b0;
    check("req", req, m_req);
  endtask
  task automatic stop_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    stop_test();
  end
  initial begin
    repeat (8) cyc();
    rst = 1'b0;
    m_req = ifm_pkg::REQ_RST;
    m_msk = ifm_pkg::MASK_RST;
    m_p0 = ifm_pkg::PRIO_RST;
    m_p1 = ifm_pkg::PRIO_RST;
    check("req", req, m_req);
    check("mask", msk, m_msk);
    check("prio", p0 & p1, ifm_pkg::PRIO_RST);
    check("psw", {40'h0, re | fe, program_status_word}, {40'h0, ifm_pkg::EDGE_RST, ifm_pkg::PSW_RST});
    $display("reset test done");
    for (int b = 0; b < 7; b++) begin
      w = {rnd(), rnd()};
      wr(ifm_pkg::OP_BYTE, ifm_pkg::GRP_MASK, b[2:0], 3'h0, w[7:0]);
      m_msk = (m_msk & ~(ifm_pkg::ONE_BYTE << (8 * b))) | ({48'h0, w[7:0]} << (8 * b));
      m_msk = m_msk | ~ifm_pkg::IMPL_MASK;
      check("mask", msk, m_msk);
    end
    wr(ifm_pkg::OP_BYTE, ifm_pkg::GRP_PSW, 3'h0, 3'h0, 8'hC3);
    check("psw", {48'h0, program_status_word}, 56'h000000000000C3);
    // Writes with a refused operation, group or byte must change nothing.
    wr(2'h3, ifm_pkg::GRP_MASK, 3'h0, 3'h0, ~m_msk[7:0]);
    wr(ifm_pkg::OP_BYTE, 3'h7, 3'h0, 3'h0, 8'h3C);
    wr(ifm_pkg::OP_BYTE, ifm_pkg::GRP_MASK, 3'h7, 3'h0, ~m_msk[7:0]);
    check("mask", msk, m_msk);
    check("psw", {48'h0, program_status_word}, 56'h000000000000C3);
    w = {rnd(), rnd()};
    wr(ifm_pkg::OP_BYTE, ifm_pkg::GRP_PRIO0, 3'h1, 3'h0, w[7:0]);
    wr(ifm_pkg::OP_CLR, ifm_pkg::GRP_PRIO1, 3'h2, 3'h3, 8'h00);
    m_p0 = (m_p0 & ~(ifm_pkg::ONE_BYTE << 8)) | ({48'h0, w[7:0]} << 8) | ~ifm_pkg::IMPL_MASK;
    m_p1[19] = 1'b0;
    check("prio0", p0, m_p0);
    check("prio1", p1, m_p1);
    $display("register test done");
    repeat (6) begin
      w = {rnd(), rnd()};
      src = w[55:0];
      cyc();
      m_req = m_req | (w[55:0] & ifm_pkg::IMPL_MASK);
      check("req", req, m_req);
      check("pend", pnd, m_req & ~m_msk);
    end
    src = 56'h0;
    ack(20);
    ack(60);
    $display("source and acknowledge test done");
    for (int i = 0; i < 9; i++) begin
      ack(sh_pos[i]);
      // Only one member of a shared flag is ever active at a time.
      sh = 9'h001 << i;
      cyc();
      sh = 9'h000;
      m_req[sh_pos[i]] = 1'b1;
      check("req", req, m_req);
    end
    $display("shared source test done");
    src = ifm_pkg::ONE_BIT << 21;
    wr(ifm_pkg::OP_CLR, ifm_pkg::GRP_REQ, 3'h2, 3'h0, 8'h00);
    src = 56'h0;
    m_req[16] = 1'b0;
    m_req[21] = 1'b1;
    check("req", req, m_req);
    wr(ifm_pkg::OP_SET, ifm_pkg::GRP_REQ, 3'h6, 3'h2, 8'h00);
    m_req[50] = 1'b1;
    check("req", req, m_req);
    $display("bit access test done");
    wr(ifm_pkg::OP_CLR, ifm_pkg::GRP_REQ, 3'h0, 3'h2, 8'h00);
    wr(ifm_pkg::OP_CLR, ifm_pkg::GRP_REQ, 3'h4, 3'h3, 8'h00);
    wr(ifm_pkg::OP_BYTE, ifm_pkg::GRP_RISE, 3'h0, 3'h0, 8'h41);
    wr(ifm_pkg::OP_BYTE, ifm_pkg::GRP_FALL, 3'h0, 3'h0, 8'h40);
    check("edges", {40'h0, re, fe}, 56'h00000000004140);
    pins = 8'h41;
    repeat (6) cyc();
    m_req[2] = 1'b1;
    m_req[35] = 1'b1;
    check("req", req, m_req);
    wr(ifm_pkg::OP_CLR, ifm_pkg::GRP_REQ, 3'h4, 3'h3, 8'h00);
    wr(ifm_pkg::OP_CLR, ifm_pkg::GRP_REQ, 3'h0, 3'h2, 8'h00);
    pins = 8'h00;
    repeat (6) cyc();
    m_req[2] = 1'b0;
    check("req", req, m_req);
    $display("pin edge test done");
    stop_test();
  end
endmodule
`default_nettype wire
